// ---- logic/tap_ident.sv ----
`timescale 1ns/1ns
`include "tap_defs.svh"
module tap_ident
  #(parameter int          BSR_LEN  = 8,      // Boundary cells
    parameter logic [3:0]  VERSION  = 4'h0,   // Arbitrary value
    parameter logic [15:0] PART_NUM = 16'h0001, // Arbitrary value
    parameter logic [10:0] MFR_ID   = 11'h001, // Arbitrary value
    parameter logic [15:0] SI_REV   = 16'h0001) // Arbitrary value
  (
    input  wire logic               core_clk_in,   // 250 MHz clock
    input  wire logic               rst_in,        // Async reset, high
    input  wire logic               clk_en_in,     // Freezes all state
    input  wire tap_pkg::probe_pins_s probe_in,    // Probe pins
    output logic                    tdo_out,       // Scan data out
    output logic                    tdo_oe_out,    // Data out driven
    input  wire logic [31:0]        security_in,   // Loaded from OTP
    input  wire logic [BSR_LEN-1:0] pin_in_in,     // Pin levels seen
    output logic [BSR_LEN-1:0]      pin_drv_out,   // Test pin values
    output logic                    extest_out,    // Pins under test
    output tap_pkg::probe_pins_s    inner_out,     // To inner port
    input  wire tap_pkg::inner_pins_s inner_in,    // From inner port
    output logic                    otp_access_out, // OTP path granted
    output tap_pkg::tap_state_e     state_out      // Controller state
  );
  import tap_pkg::*;

  // Refuse a boundary chain that the shared 32-bit shifter cannot hold
  if (BSR_LEN < 1 || BSR_LEN > `TAP_DR_LEN)
  begin : g_bad_bsr_len
    $error("BSR_LEN out of range");
  end

  // Three-stage synchronisers; only stages two and three are compared
  logic [2:0] tck_sync, tms_sync, tdi_sync;
  logic       tck_seen, tms_seen, tdi_seen;
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      tck_sync <= 3'h0;
      tms_sync <= 3'h7;
      tdi_sync <= 3'h0;
    end
    else if (clk_en_in)
    begin
      tck_sync <= {tck_sync[1:0], probe_in.tck};
      tms_sync <= {tms_sync[1:0], probe_in.tms};
      tdi_sync <= {tdi_sync[1:0], probe_in.tdi};
    end

  // A change counts once stages two and three agree
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      tck_seen <= 1'b0;
      tms_seen <= 1'b1;
      tdi_seen <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (tck_sync[1] == tck_sync[2]) tck_seen <= tck_sync[2];
      if (tms_sync[1] == tms_sync[2]) tms_seen <= tms_sync[2];
      if (tdi_sync[1] == tdi_sync[2]) tdi_seen <= tdi_sync[2];
    end

  // Edge strobes of the test clock
  logic tck_prev;
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      tck_prev <= 1'b0;
    else if (clk_en_in)
      tck_prev <= tck_seen;

  wire port_off = security_in[`SEC_TAP_OFF_BIT];
  wire tck_rise = clk_en_in & tck_seen & ~tck_prev & ~port_off;
  wire tck_fall = clk_en_in & ~tck_seen & tck_prev & ~port_off;

  // Controller next state
  tap_state_e state, next_state;
  always_comb
  begin
    unique case (state)
      ST_RESET:    next_state = tms_seen ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = tms_seen ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = tms_seen ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = tms_seen ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms_seen ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms_seen ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms_seen ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms_seen ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = tms_seen ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = tms_seen ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = tms_seen ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms_seen ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms_seen ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms_seen ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms_seen ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = tms_seen ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // The sequence guarantees reset after five highs from any state; the
  // count also forces it should the state ever be upset.
  logic [2:0] tms_high_cnt;
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      tms_high_cnt <= 3'h0;
    else if (tck_rise)
      tms_high_cnt <= !tms_seen ? 3'h0 :
        (tms_high_cnt == `TAP_TMS_RESET_CNT ? tms_high_cnt
                                             : tms_high_cnt + 3'h1);

  wire force_reset = tms_seen &&
                     (tms_high_cnt == `TAP_TMS_RESET_CNT - 3'h1);

  // Port disable holds the controller in reset
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      state <= ST_RESET;
    else if (clk_en_in && port_off)
      state <= ST_RESET;
    else if (tck_rise)
      state <= force_reset ? ST_RESET : next_state;

  // Instruction decode
  logic [`TAP_IR_LEN-1:0] ir_shift, ir;
  wire sel_id     = (ir == `TAP_INS_DEVICE_IDENTIFICATION);
  wire sel_user   = (ir == `TAP_INS_USERCODE);
  wire sel_bsr    = (ir == `TAP_INS_EXTEST) ||
                    (ir == `TAP_INS_SAMPLE);
  wire sel_inner  = (ir == `TAP_INS_CHIPTAP);
  wire otp_locked = security_in[`SEC_OTP_LOCK_BIT];

  // Capture words of the identity paths
  wire [31:0] id_word = {VERSION, PART_NUM, MFR_ID, 1'b1};
  wire [31:0] user_word = {security_in[`SEC_USER_MSB:`SEC_USER_LSB],
                           6'h00, SI_REV};

  // Instruction register
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      ir_shift <= `TAP_IR_CAPTURE;
      ir       <= `TAP_INS_DEVICE_IDENTIFICATION;
    end
    else if (tck_rise)
    begin
      if (state == ST_RESET)
        ir <= `TAP_INS_DEVICE_IDENTIFICATION;
      else if (state == ST_UPD_IR)
        ir <= ir_shift;
      if (state == ST_CAP_IR)
        ir_shift <= `TAP_IR_CAPTURE;
      else if (state == ST_SHIFT_IR)
        ir_shift <= {tdi_seen, ir_shift[`TAP_IR_LEN-1:1]};
    end

  // Data register: one 32-bit shifter shared by every path but the inner-port gateway
  logic [`TAP_DR_LEN-1:0] dr;
  logic [BSR_LEN-1:0]     bsr_upd;
  wire [`TAP_DR_LEN-1:0] bsr_cap = `TAP_DR_LEN'(pin_in_in);
  wire [`TAP_DR_LEN-1:0] dr_cap  = sel_id   ? id_word :
                                   sel_user ? user_word :
                                   sel_bsr  ? bsr_cap : '0;
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      dr <= 32'h00000000;
    else if (tck_rise)
    begin
      if (state == ST_CAP_DR)
        dr <= dr_cap;
      else if (state == ST_SHIFT_DR)
        dr <= {tdi_seen, dr[`TAP_DR_LEN-1:1]};
    end

  // Boundary update stage drives the pins under EXTEST
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
      bsr_upd <= '0;
    else if (tck_rise && state == ST_UPD_DR && sel_bsr)
      bsr_upd <= dr[BSR_LEN-1:0];
  assign pin_drv_out = bsr_upd;
  assign extest_out  = (ir == `TAP_INS_EXTEST) && !port_off;

  // Gateway to the inner chip-level port for load, debug and OTP work
  assign otp_access_out = sel_inner && !port_off && !otp_locked;
  assign inner_out.tck  = sel_inner && !port_off && probe_in.tck;
  assign inner_out.tms  = probe_in.tms;
  assign inner_out.tdi  = probe_in.tdi;

  // Data-out changes on the falling test-clock edge
  wire shifting = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
  wire tdo_next = (state == ST_SHIFT_IR) ? ir_shift[0] :
                  sel_inner ? inner_in.tdo : dr[0];
  always_ff @(posedge core_clk_in or posedge rst_in)
    if (rst_in)
    begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end
    else if (clk_en_in && port_off)
      tdo_oe_out <= 1'b0;
    else if (tck_fall)
    begin
      tdo_out    <= tdo_next;
      tdo_oe_out <= shifting;
    end
  assign state_out = state;

  // Five rising edges with mode-select high end in reset
  property p_tms_reset;
    @(posedge core_clk_in) disable iff (rst_in)
      (tck_rise && force_reset) |=> (state == ST_RESET);
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("controller missed forced reset");

  property p_reset_loads_id;
    @(posedge core_clk_in) disable iff (rst_in)
      (tck_rise && state == ST_RESET) |=> (ir == `TAP_INS_DEVICE_IDENTIFICATION);
  endproperty
  a_reset_loads_id: assert property (p_reset_loads_id)
    else $error("reset did not select identification");

  property p_id_capture;
    @(posedge core_clk_in) disable iff (rst_in)
      (tck_rise && state == ST_CAP_DR && sel_id) |=> (dr[0] == 1'b1);
  endproperty
  a_id_capture: assert property (p_id_capture)
    else $error("identification lowest bit not one");

  property p_user_field;
    @(posedge core_clk_in) disable iff (rst_in)
      (tck_rise && state == ST_CAP_DR && sel_user && $stable(security_in))
      |=> (dr[31:22] == security_in[31:22]);
  endproperty
  a_user_field: assert property (p_user_field)
    else $error("user field not from security word");

  property p_port_off;
    @(posedge core_clk_in) disable iff (rst_in)
      (clk_en_in && port_off) |=> (state == ST_RESET) && !tdo_oe_out;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("disabled port still active");

  property p_otp_lock;
    @(posedge core_clk_in) disable iff (rst_in)
      otp_locked |-> !otp_access_out;
  endproperty
  a_otp_lock: assert property (p_otp_lock)
    else $error("OTP reachable while locked");

  property p_tdo_on_fall;
    @(posedge core_clk_in) disable iff (rst_in)
      !tck_fall |=> $stable(tdo_out) || $past(port_off);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("data-out moved off the falling edge");

  property p_dr_shift;
    @(posedge core_clk_in) disable iff (rst_in)
      (tck_rise && state == ST_SHIFT_DR)
      |=> (dr[30:0] == $past(dr[31:1]));
  endproperty
  a_dr_shift: assert property (p_dr_shift)
    else $error("data path did not shift by one");
endmodule // tap_ident

// ---- include/tap_defs.svh ----
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH
// Scan path lengths
`define TAP_IR_LEN        4
`define TAP_DR_LEN        32
// Instruction codes (bypass is all ones)
`define TAP_INS_EXTEST    4'h0
`define TAP_INS_SAMPLE    4'h1
`define TAP_INS_DEVICE_IDENTIFICATION    4'h2
`define TAP_INS_USERCODE  4'h3
`define TAP_INS_CHIPTAP   4'h4
`define TAP_INS_BYPASS    4'hF
// Capture pattern of the instruction path
`define TAP_IR_CAPTURE    4'h1
// Identification value layout
`define ID_VER_MSB        31
`define ID_VER_LSB        28
`define ID_PART_MSB       27
`define ID_PART_LSB       12
`define ID_MFR_MSB        11
`define ID_MFR_LSB        1
// User code layout and its source in the security word
`define UC_USER_MSB       31
`define UC_USER_LSB       22
`define UC_REV_MSB        15
`define UC_REV_LSB        0
`define SEC_USER_MSB      31
`define SEC_USER_LSB      22
`define SEC_TAP_OFF_BIT   0
`define SEC_OTP_LOCK_BIT  13
// Count of mode-select highs that forces reset
`define TAP_TMS_RESET_CNT 3'h5
`endif

// ---- include/tap_pkg.sv ----
package tap_pkg;
  // Controller states, standard sixteen-state sequence
  typedef enum logic [3:0] {
    ST_RESET    = 4'h0, ST_IDLE     = 4'h1, ST_SEL_DR  = 4'h2,
    ST_CAP_DR   = 4'h3, ST_SHIFT_DR = 4'h4, ST_EXIT1_DR = 4'h5,
    ST_PAUSE_DR = 4'h6, ST_EXIT2_DR = 4'h7, ST_UPD_DR  = 4'h8,
    ST_SEL_IR   = 4'h9, ST_CAP_IR   = 4'hA, ST_SHIFT_IR = 4'hB,
    ST_EXIT1_IR = 4'hC, ST_PAUSE_IR = 4'hD, ST_EXIT2_IR = 4'hE,
    ST_UPD_IR   = 4'hF
  } tap_state_e;
  // Pins coming from the probe
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } probe_pins_s;
  // Answer of the inner chip-level port
  typedef struct packed {
    logic tdo;
  } inner_pins_s;
endpackage

// ---- testbench/jtag_probe_model.sv ----
`timescale 1ns/1ns
// Behavioural probe: paces the test clock off the bench clock so that
// every pin change lands just after a system clock edge
module jtag_probe_model
  import tap_pkg::*;
  (
    input  wire logic           clk_in,   // Bench clock for pacing
    input  wire logic           tdo_in,   // Scan data from the port
    output tap_pkg::probe_pins_s pins_out // Probe pins
  );
  // Test clock low, mode-select high, so the port idles in reset
  initial pins_out = 3'b010;

  // One test clock of 80 ns; tck stands low between calls
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    pins_out.tms = tms;
    pins_out.tdi = tdi;
    repeat (10) @(posedge clk_in);
    #1;
    tdo = tdo_in;          // Data-out sampled just before the rise
    pins_out.tck = 1'b1;   // Inputs taken on the rising edge
    repeat (10) @(posedge clk_in);
    #1;
    pins_out.tck = 1'b0;
  endtask

  // Full scan from idle and back; data-in outside the shift is toggled
  // so a stale level can never pass for a shifted bit
  task automatic scan(input logic ir, input logic [31:0] din,
                      input int n, output logic [31:0] dout);
    logic t;
    tick(1'b1, ~pins_out.tdi, t);
    if (ir)
      tick(1'b1, ~pins_out.tdi, t);
    tick(1'b0, ~pins_out.tdi, t);
    tick(1'b0, ~pins_out.tdi, t);
    dout = 32'h00000000;
    // Exactly n bits, least significant first
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], t);
      dout = {t, dout[31:1]};
    end
    dout = dout >> (32 - n);
    tick(1'b1, ~pins_out.tdi, t);
    tick(1'b0, ~pins_out.tdi, t);
  endtask

  // Five test clocks with mode-select high
  task automatic reset5();
    logic t;
    repeat (5) tick(1'b1, ~pins_out.tdi, t);
  endtask
endmodule // jtag_probe_model

// ---- testbench/test_jtag_tap_identification.sv ----
`timescale 1ns/1ns
module test_jtag_tap_identification;
  import tap_pkg::*;
  // Identity values are arbitrary
  localparam logic [3:0]  VER  = 4'h3;
  localparam logic [15:0] PART = 16'h1234;
  localparam logic [10:0] MFR  = 11'h2A5;
  localparam logic [15:0] REV  = 16'h00C7;
  localparam logic [31:0] IDV  = {VER, PART, MFR, 1'b1};

  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic [31:0] security_in = 32'h00000000;
  logic [7:0]  pin_in_in   = 8'h5A;
  inner_pins_s inner_in;
  probe_pins_s probe;
  probe_pins_s inner_out;
  tap_state_e  state_out;
  logic [7:0]  pin_drv_out;
  logic        tdo_out, tdo_oe_out, extest_out, otp_access_out, t;
  logic [31:0] got;
  int          num_errors = 0;
  int          n_compared = 0;

  // 250 MHz system clock
  always #2 core_clk_in = ~core_clk_in;

  // Inner port modelled as a plain wire: data-in comes straight back, so
  // a gateway scan returns exactly what was shifted in
  assign inner_in.tdo = inner_out.tdi;

  tap_ident #(.BSR_LEN(8), .VERSION(VER), .PART_NUM(PART),
              .MFR_ID(MFR), .SI_REV(REV)) uut
    (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
     .probe_in(probe), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
     .security_in(security_in), .pin_in_in(pin_in_in),
     .pin_drv_out(pin_drv_out), .extest_out(extest_out),
     .inner_out(inner_out), .inner_in(inner_in),
     .otp_access_out(otp_access_out), .state_out(state_out));

  jtag_probe_model probe_m
    (.clk_in(core_clk_in), .tdo_in(tdo_out), .pins_out(probe));

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_flag(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    repeat (8) @(posedge core_clk_in);
    #1;
    check_word(32'(state_out), 32'(ST_RESET));
    probe_m.tick(1'b0, 1'b0, t);
    probe_m.scan(1'b0, 32'h00000000, 32, got);
    check_word(got, IDV);
    security_in = 32'hB7C00000;
    probe_m.scan(1'b1, 32'h00000003, 4, got);
    check_word(got, 32'h00000001);
    probe_m.scan(1'b0, 32'h00000000, 32, got);
    check_word(got, {10'h2DF, 6'h00, REV});
    security_in = 32'h00000000;
    probe_m.scan(1'b0, 32'h00000000, 32, got);
    check_word(got, {16'h0000, REV});
    probe_m.scan(1'b1, 32'h00000000, 4, got);
    check_flag(extest_out, 1'b1);
    // Pins are captured on the way out, shifted-in values drive them
    probe_m.scan(1'b0, 32'h000000A5, 32, got);
    check_word(got, 32'h0000005A);
    check_word(32'(pin_drv_out), 32'h000000A5);
    probe_m.scan(1'b1, 32'h00000001, 4, got);
    check_flag(extest_out, 1'b0);
    probe_m.scan(1'b1, 32'h00000004, 4, got);
    check_flag(otp_access_out, 1'b1);
    probe_m.scan(1'b0, 32'hC35A96E1, 32, got);
    check_word(got, 32'hC35A96E1);
    security_in = 32'h00002000;
    @(posedge core_clk_in);
    #1;
    check_flag(otp_access_out, 1'b0);
    probe_m.scan(1'b1, 32'h0000000F, 4, got);
    probe_m.scan(1'b0, 32'hFFFFFFFF, 32, got);
    check_word(got, 32'h00000000);
    probe_m.reset5();
    check_word(32'(state_out), 32'(ST_RESET));
    probe_m.tick(1'b0, 1'b0, t);
    probe_m.scan(1'b0, 32'h00000000, 32, got);
    check_word(got, IDV);
    // Park in Shift-DR so the disable lands while data-out is driven
    probe_m.tick(1'b1, 1'b0, t);
    probe_m.tick(1'b0, 1'b0, t);
    probe_m.tick(1'b0, 1'b0, t);
    repeat (8) @(posedge core_clk_in);
    #1;
    check_flag(tdo_oe_out, 1'b1);
    security_in = 32'h00000001;
    probe_m.scan(1'b1, 32'h00000003, 4, got);
    check_word(32'(state_out), 32'(ST_RESET));
    check_flag(tdo_oe_out, 1'b0);
    complete_run();
  end

  // Hang guard: a stuck run counts as a mismatch
  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    num_errors++;
    complete_run();
  end
endmodule // test_jtag_tap_identification
